// ### tmcs_timer.sv
// Timer control/status block with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
module tmcs_timer
  import tmcs_pkg::*;
(
  input  wire logic        ref_clk_in,    // 40 MHz clock
  input  wire logic        rst_b_in,      // Async reset, low
  input  wire logic        ce_in,         // Clock enable
  input  wire logic        osc_pin_in,    // Oscillator pin
  input  wire logic [2:0]  vector_ack_in, // Vector taken {b,a,ovf}
  input  wire logic [11:0] awaddr_in,     // AXI write address
  input  wire logic        awvalid_in,    // AXI
  output logic             awready_out,   // AXI
  input  wire logic [31:0] wdata_in,      // AXI write data
  input  wire logic [3:0]  wstrb_in,      // AXI strobes
  input  wire logic        wvalid_in,     // AXI
  output logic             wready_out,    // AXI
  output logic [1:0]       bresp_out,     // AXI
  output logic             bvalid_out,    // AXI
  input  wire logic        bready_in,     // AXI
  input  wire logic [11:0] araddr_in,     // AXI read address
  input  wire logic        arvalid_in,    // AXI
  output logic             arready_out,   // AXI
  output logic [31:0]      rdata_out,     // AXI read data
  output logic [1:0]       rresp_out,     // AXI
  output logic             rvalid_out,    // AXI
  input  wire logic        rready_in,     // AXI
  output logic             wave_out_a,    // Channel A output
  output logic             wave_out_b,    // Channel B output
  output logic             irq_out,       // Level interrupt
  output logic             osc_run_out,   // Crystal enable
  output logic             ext_buf_out    // Pin clock buffer enable
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic         osc_s1_r, osc_s2_r, osc_s3_r;
  logic [9:0]   psc_r;
  logic [7:0]   cnt_r, mta_r, mtb_r, mask_r;
  logic [7:0]   cnt_t_r, mta_t_r, mtb_t_r;
  tmcs_ctrl_a_t ca_r, ca_t_r;
  tmcs_ctrl_b_t cb_r, cb_t_r;
  logic [4:0]   pend_r;
  logic [1:0]   frc_r;
  logic         external_clock_enable_r, as_r, tsm_r, psr_r, gie_r;
  logic         down_r, blk_r;
  logic [2:0]   flg_r, flg_nxt;
  logic         aw_h_r, w_h_r, awrdy_r, wrdy_r;
  logic [9:0]   awi_r;
  logic [7:0]   wd_r;
  logic         wlane_r;
  logic         bvalid_r, arrdy_r, rvalid_r;
  logic [1:0]   bresp_r, rresp_r;
  logic [7:0]   rdata_r;
  logic         wa_r, wb_r, irq_r, oscrun_r, extbuf_r;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire       aw_take = awvalid_in & awrdy_r;
  wire       w_take  = wvalid_in & wrdy_r;
  wire       wr_go   = ce_in & aw_h_r & w_h_r & ~bvalid_r;
  wire       wr      = wr_go & wlane_r;
  wire       ar_take = ce_in & arvalid_in & arrdy_r;
  wire [9:0] ari     = araddr_in[11:2];
  wire w_mask  = wr & (awi_r == IDX_MASK);
  wire w_ca    = wr & (awi_r == IDX_CTRL_A);
  wire w_cb    = wr & (awi_r == IDX_CTRL_B);
  wire w_cnt   = wr & (awi_r == IDX_COUNT);
  wire w_mta   = wr & (awi_r == IDX_MATCH_A);
  wire w_mtb   = wr & (awi_r == IDX_MATCH_B);
  wire w_async = wr & (awi_r == IDX_ASYNC);
  wire w_flg   = wr & (awi_r == IDX_FLAGS);
  wire w_fclr  = wr & (awi_r == IDX_FCLR);
  wire w_gtc   = wr & (awi_r == IDX_GTC);
  wire w_gie   = wr & (awi_r == IDX_GIE);
  wire wr_hit  = (awi_r == IDX_MASK) | (awi_r == IDX_CTRL_A)
               | (awi_r == IDX_CTRL_B) | (awi_r == IDX_COUNT)
               | (awi_r == IDX_MATCH_A) | (awi_r == IDX_MATCH_B)
               | (awi_r == IDX_ASYNC) | (awi_r == IDX_FLAGS)
               | (awi_r == IDX_FCLR) | (awi_r == IDX_GTC)
               | (awi_r == IDX_GIE);

  // ----------------------------------------
  // Timer clock and prescaler
  // ----------------------------------------
  // Pin edge only from the second and third stages
  wire osc_edge  = osc_s2_r & ~osc_s3_r;
  wire base_tick = ce_in & (as_r ? osc_edge : 1'b1);
  wire [9:0] tap = (cb_r.cs == 3'd2) ? DIV8 :
                   (cb_r.cs == 3'd3) ? DIV32 :
                   (cb_r.cs == 3'd4) ? DIV64 :
                   (cb_r.cs == 3'd5) ? DIV128 :
                   (cb_r.cs == 3'd6) ? DIV256 : DIV1024;
  wire tick = base_tick & (cb_r.cs != 3'd0)
            & ((cb_r.cs == 3'd1) | ((psc_r & tap) == tap));

  // ----------------------------------------
  // Mode decode and compare
  // ----------------------------------------
  wire [2:0] wgm   = {cb_r.wave_msb, ca_r.wave_low};
  wire       phase = (ca_r.wave_low == 2'b01);
  wire       pwm   = ca_r.wave_low[0];
  wire       top_a = (wgm == 3'b010) | (wgm == 3'b101)
                   | (wgm == 3'b111);
  wire [7:0] top   = top_a ? mta_r : MAX_CNT;
  wire eq_a = (cnt_r == mta_r);
  wire eq_b = (cnt_r == mtb_r);
  wire ma = tick & ~blk_r & eq_a;
  wire mb = tick & ~blk_r & eq_b;
  // wrap, or turn at bottom in phase mode
  wire ovf = tick & (phase ? (down_r & (cnt_r == 8'h00))
                           : (cnt_r == (pwm ? top : MAX_CNT)));
  // Transfers from temporary copies; sync mode moves them at once
  wire xfer = ~as_r | base_tick;
  wire c_cnt = pend_r[4] & xfer;
  wire c_cb  = pend_r[0] & xfer;
  // force acts only in non-PWM modes
  wire fa = c_cb & frc_r[1] & ~pwm;
  wire fb = c_cb & frc_r[0] & ~pwm;
  wire act_a = (ma & ~pwm) | fa;
  wire act_b = (mb & ~pwm) | fb;

  // Next count value; clear-on-match comes from top only
  logic [7:0] cnt_nx;
  logic       down_nx;
  always_comb begin
    cnt_nx  = cnt_r + 8'h01;
    down_nx = down_r;
    if (phase) begin
      if (!down_r && cnt_r == top) begin
        down_nx = 1'b1;
        cnt_nx  = cnt_r - 8'h01;
      end else if (down_r && cnt_r == 8'h00) begin
        down_nx = 1'b0;
      end else if (down_r) begin
        cnt_nx = cnt_r - 8'h01;
      end
    end else if (cnt_r == top) begin
      cnt_nx = 8'h00;
    end
  end

  function automatic logic do_act(input logic [1:0] act,
                                  input logic       cur);
    logic r;
    r = cur;
    if (act == ACT_TOGGLE) r = ~cur;
    if (act == ACT_CLEAR)  r = 1'b0;
    if (act == ACT_SET)    r = 1'b1;
    return r;
  endfunction

  wire [2:0] flg_clr = vector_ack_in
                     | ({3{w_flg}} & wd_r[2:0])
                     | ({3{w_fclr}} & wd_r[2:0]);
  wire [2:0] flg_set = {mb, ma, ovf};
  assign flg_nxt = (flg_r & ~flg_clr) | flg_set;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // busy shown only while async
  wire [7:0] async_rd = {1'b0, external_clock_enable_r, as_r, pend_r & {5{as_r}}};
  wire [7:0] cb_rd = {4'h0, cb_t_r.wave_msb, cb_t_r.cs};
  wire [7:0] ca_rd = {ca_t_r.act_a, ca_t_r.act_b, 2'b00,
                      ca_t_r.wave_low};
  wire [7:0] rd_mux =
    (ari == IDX_MASK)    ? {5'h00, mask_r[2:0]} :
    (ari == IDX_CTRL_A)  ? ca_rd :
    (ari == IDX_CTRL_B)  ? cb_rd :
    (ari == IDX_COUNT)   ? cnt_r :
    (ari == IDX_MATCH_A) ? mta_t_r :
    (ari == IDX_MATCH_B) ? mtb_t_r :
    (ari == IDX_ASYNC)   ? async_rd :
    (ari == IDX_FLAGS)   ? {5'h00, flg_r} :
    (ari == IDX_GTC)     ? {tsm_r, 5'h00, psr_r, 1'b0} :
    (ari == IDX_GIE)     ? {7'h00, gie_r} : 8'h00;
  wire rd_hit = (ari == IDX_MASK) | (ari == IDX_CTRL_A)
              | (ari == IDX_CTRL_B) | (ari == IDX_COUNT)
              | (ari == IDX_MATCH_A) | (ari == IDX_MATCH_B)
              | (ari == IDX_ASYNC) | (ari == IDX_FLAGS)
              | (ari == IDX_FCLR) | (ari == IDX_GTC)
              | (ari == IDX_GIE);

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end else if (ce_in) begin
      osc_s1_r <= osc_pin_in;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end

  // ----------------------------------------
  // AXI4-Lite handshake
  // ----------------------------------------
  // One write and one read at a time keeps the slave small
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aw_h_r <= 1'b0;
      w_h_r <= 1'b0;
      awrdy_r <= 1'b0;
      wrdy_r <= 1'b0;
      awi_r <= 10'h000;
      wd_r <= RST_BYTE;
      wlane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arrdy_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= RST_BYTE;
    end else if (ce_in) begin
      awrdy_r <= ~aw_h_r & ~aw_take & ~bvalid_r;
      wrdy_r <= ~w_h_r & ~w_take & ~bvalid_r;
      if (aw_take) begin
        aw_h_r <= 1'b1;
        awi_r <= awaddr_in[11:2];
      end
      if (w_take) begin
        w_h_r <= 1'b1;
        wd_r <= wdata_in[7:0];
        wlane_r <= wstrb_in[0];
      end
      if (wr_go) begin
        aw_h_r <= 1'b0;
        w_h_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && bready_in) begin
        bvalid_r <= 1'b0;
      end
      if (ar_take) begin
        arrdy_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && rready_in) begin
        rvalid_r <= 1'b0;
        arrdy_r <= 1'b1;
      end else if (!rvalid_r) begin
        arrdy_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Software registers and temporary copies
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mask_r <= RST_BYTE;
      gie_r <= 1'b0;
      external_clock_enable_r <= 1'b0;
      as_r <= 1'b0;
      tsm_r <= 1'b0;
      cnt_t_r <= RST_BYTE;
      mta_t_r <= RST_BYTE;
      mtb_t_r <= RST_BYTE;
      ca_t_r <= '0;
      cb_t_r <= '0;
      frc_r <= 2'b00;
      pend_r <= 5'h00;
    end else if (ce_in) begin
      if (w_mask) mask_r <= {5'h00, wd_r[2:0]};
      if (w_gie) gie_r <= wd_r[0];
      if (w_async) begin
        external_clock_enable_r <= wd_r[B_EXTERNAL_CLOCK_ENABLE];
        as_r <= wd_r[B_AS];
      end
      if (w_gtc) tsm_r <= wd_r[B_TSM];
      pend_r <= (pend_r & ~{5{xfer}})
              | {w_cnt, w_mta, w_mtb, w_ca, w_cb};
      if (w_cnt) cnt_t_r <= wd_r;
      if (w_mta) mta_t_r <= wd_r;
      if (w_mtb) mtb_t_r <= wd_r;
      if (w_ca) ca_t_r <= tmcs_ctrl_a_t'(wd_r);
      if (w_cb) begin
        cb_t_r <= tmcs_ctrl_b_t'({4'h0, wd_r[3:0]});
        frc_r <= wd_r[7:6];
      end
    end
  end

  // ----------------------------------------
  // Live registers and counter
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_r <= RST_BYTE;
      mta_r <= RST_BYTE;
      mtb_r <= RST_BYTE;
      ca_r <= '0;
      cb_r <= '0;
      down_r <= 1'b0;
      blk_r <= 1'b0;
    end else if (ce_in) begin
      if (pend_r[3] && xfer) mta_r <= mta_t_r;
      if (pend_r[2] && xfer) mtb_r <= mtb_t_r;
      if (pend_r[1] && xfer) ca_r <= ca_t_r;
      if (c_cb) cb_r <= cb_t_r;
      // written value wins and blocks next match
      if (c_cnt) begin
        cnt_r <= cnt_t_r;
        blk_r <= 1'b1;
      end else if (tick) begin
        cnt_r <= cnt_nx;
        down_r <= down_nx;
        blk_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Prescaler and its reset bit
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      psc_r <= 10'h000;
      psr_r <= 1'b0;
    end else if (ce_in) begin
      // reset held until a timer clock edge with tsm_r clear
      if (psr_r) psc_r <= 10'h000;
      else if (base_tick) psc_r <= psc_r + 10'h001;
      if (w_gtc && wd_r[B_PSR]) psr_r <= 1'b1;
      else if (psr_r && !tsm_r && xfer) psr_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Flags, interrupt and pin outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flg_r <= 3'b000;
      irq_r <= 1'b0;
      wa_r <= 1'b0;
      wb_r <= 1'b0;
      oscrun_r <= 1'b0;
      extbuf_r <= 1'b0;
    end else if (ce_in) begin
      flg_r <= flg_nxt;
      irq_r <= gie_r & |(flg_r & mask_r[2:0]);
      if (act_a) wa_r <= do_act(ca_r.act_a, wa_r);
      if (act_b) wb_r <= do_act(ca_r.act_b, wb_r);
      oscrun_r <= as_r & ~external_clock_enable_r;
      extbuf_r <= as_r & external_clock_enable_r;
    end
  end

  assign awready_out = awrdy_r;
  assign wready_out  = wrdy_r;
  assign bvalid_out  = bvalid_r;
  assign bresp_out   = bresp_r;
  assign arready_out = arrdy_r;
  assign rvalid_out  = rvalid_r;
  assign rresp_out   = rresp_r;
  assign rdata_out   = {24'h000000, rdata_r};
  assign wave_out_a  = wa_r;
  assign wave_out_b  = wb_r;
  assign irq_out     = irq_r;
  assign osc_run_out = oscrun_r;
  assign ext_buf_out = extbuf_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb_clk @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_cnt_write;
    ce_in & c_cnt;
  endsequence

  property p_stop;
    (cb_r.cs == 3'd0) |-> !tick;
  endproperty
  a_stop: assert property (p_stop) else $error("tick while stopped");

  property p_block;
    s_cnt_write |=> blk_r && !ma && !mb;
  endproperty
  a_block: assert property (p_block) else $error("match not blocked");

  property p_irq;
    ce_in & $past(ce_in) |-> irq_out == $past(gie_r & |(flg_r & mask_r[2:0]));
  endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");

  property p_flag;
    ce_in & ma |=> flg_r[1];
  endproperty
  a_flag: assert property (p_flag) else $error("match flag missed");

  property p_force;
    ce_in & fa & !ma & !flg_r[1] & !vector_ack_in[1] |=> !flg_r[1];
  endproperty
  a_force: assert property (p_force) else $error("force set a flag");

  property p_busy;
    ce_in & w_cnt & as_r |=> async_rd[4] || !as_r;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not set");

  property p_rd;
    ce_in & ar_take & (ari == IDX_CTRL_B) |=> rvalid_out && rdata_out[7:4] == 4'h0;
  endproperty
  a_rd: assert property (p_rd) else $error("control B high bits");

  property p_psr;
    ce_in & psr_r & !as_r & !tsm_r & !w_gtc |=> !psr_r;
  endproperty
  a_psr: assert property (p_psr) else $error("prescaler bit stuck");

  property p_osc;
    ce_in & as_r & external_clock_enable_r |=> !osc_run_out && ext_buf_out;
  endproperty
  a_osc: assert property (p_osc) else $error("crystal still on");

  property p_toggle;
    ce_in & ma & !pwm & (ca_r.act_a == ACT_TOGGLE) |=> wave_out_a != $past(wave_out_a);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle");

endmodule
`default_nettype wire

// ### tmcs_pkg.sv
// Constants and carrier types of the asynchronous timer control block
package tmcs_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_MASK   = 10'h070;
  localparam logic [9:0] IDX_CTRL_A = 10'h0B0;
  localparam logic [9:0] IDX_CTRL_B = 10'h0B1;
  localparam logic [9:0] IDX_COUNT  = 10'h0B2;
  localparam logic [9:0] IDX_MATCH_A = 10'h0B3;
  localparam logic [9:0] IDX_MATCH_B = 10'h0B4;
  localparam logic [9:0] IDX_ASYNC  = 10'h0B6;
  localparam logic [9:0] IDX_FLAGS  = 10'h037;
  localparam logic [9:0] IDX_FCLR   = 10'h038;
  localparam logic [9:0] IDX_GTC    = 10'h043;
  localparam logic [9:0] IDX_GIE    = 10'h05F;
  // Bit positions
  localparam int B_EXTERNAL_CLOCK_ENABLE = 6;
  localparam int B_AS    = 5;
  localparam int B_TSM   = 7;
  localparam int B_PSR   = 1;
  // Reset value of every byte register
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] MAX_CNT  = 8'hFF;
  // Prescaler taps: low bits all ones give divide by 2^n
  localparam logic [9:0] DIV8    = 10'h007;
  localparam logic [9:0] DIV32   = 10'h01F;
  localparam logic [9:0] DIV64   = 10'h03F;
  localparam logic [9:0] DIV128  = 10'h07F;
  localparam logic [9:0] DIV256  = 10'h0FF;
  localparam logic [9:0] DIV1024 = 10'h3FF;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Output actions
  localparam logic [1:0] ACT_TOGGLE = 2'b01;
  localparam logic [1:0] ACT_CLEAR  = 2'b10;
  localparam logic [1:0] ACT_SET    = 2'b11;

  typedef struct packed {
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic [1:0] rsvd;
    logic [1:0] wave_low;
  } tmcs_ctrl_a_t;

  typedef struct packed {
    logic       force_a;
    logic       force_b;
    logic [1:0] rsvd;
    logic       wave_msb;
    logic [2:0] cs;
  } tmcs_ctrl_b_t;
endpackage

// ### test_tmcs_timer.sv
// Self-checking bench of the timer control/status block
`timescale 1ns/1ps
`default_nettype none
module test_tmcs_timer import tmcs_pkg::*;;
  // --------------
  // Signals and design
  // --------------
  logic        clk = 1'b0;
  logic        rst_b, osc, bready, rready, awvalid, wvalid, arvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdat;
  logic [2:0]  vack;
  logic [1:0]  brsp, rrsp;
  wire         awready, wready, bvalid, arready, rvalid;
  wire         wave_a, wave_b, irq, osc_run, ext_buf;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          err_total = 0;
  int          n_tests = 0;

  // Clock enable and byte strobe stay on; the freeze path is not exercised
  tmcs_timer i_tmcs_timer (
    .ref_clk_in(clk), .rst_b_in(rst_b), .ce_in(1'b1), .osc_pin_in(osc),
    .vector_ack_in(vack), .awaddr_in(awaddr), .awvalid_in(awvalid),
    .awready_out(awready), .wdata_in(wdata), .wstrb_in(4'h1),
    .wvalid_in(wvalid), .wready_out(wready), .bresp_out(bresp),
    .bvalid_out(bvalid), .bready_in(bready), .araddr_in(araddr),
    .arvalid_in(arvalid), .arready_out(arready), .rdata_out(rdata),
    .rresp_out(rresp), .rvalid_out(rvalid), .rready_in(rready),
    .wave_out_a(wave_a), .wave_out_b(wave_b), .irq_out(irq),
    .osc_run_out(osc_run), .ext_buf_out(ext_buf));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // --------------
  // Shared tasks
  // --------------
  // Compares and keeps the tallies
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Handshakes are judged at the falling edge, so no race with the design's edge
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    logic ta, tw, tb;
    int   n;
    tb = 1'b0;
    n = 0;
    awaddr  <= {i, 2'b00};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!tb && n < 50) begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      brsp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    // One idle edge so the next call never re-raises bready in this step
    tick(1);
    chk("write answer", 32'(tb), 32'h1);
  endtask

  task automatic rd(input logic [9:0] i);
    logic ta, tr;
    int   n;
    tr = 1'b0;
    n = 0;
    araddr  <= {i, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!tr && n < 50) begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid;
      rdat = rdata;
      rrsp = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    tick(1);
    chk("read answer", 32'(tr), 32'h1);
  endtask

  task automatic rc(input logic [9:0] i, input logic [7:0] e);
    rd(i);
    chk($sformatf("reg %h", i), rdat, {24'h0, e});
  endtask

  // Registered pins settle a few cycles after the bus write
  task automatic pc(input string nm, input logic s, input logic e);
    tick(3);
    chk(nm, 32'(s), 32'(e));
  endtask

  // Four rising edges on the oscillator pin, slow enough for the synchroniser
  task automatic edges;
    repeat (8) begin
      tick(4);
      osc <= ~osc;
    end
  endtask

  // --------------
  // Scenarios
  // --------------
  task automatic t_force;
    rc(IDX_MASK, 8'h00);
    rc(IDX_CTRL_B, 8'h00);
    rc(IDX_ASYNC, 8'h00);
    wr(IDX_CTRL_A, 8'hD0);
    wr(IDX_CTRL_B, 8'hC0);
    pc("force a set", wave_a, 1'b1);
    pc("force b toggle", wave_b, 1'b1);
    rc(IDX_CTRL_B, 8'h00);
    rc(IDX_FLAGS, 8'h00);
    wr(IDX_CTRL_A, 8'h90);
    wr(IDX_CTRL_B, 8'hC0);
    pc("force a clear", wave_a, 1'b0);
    pc("force b back", wave_b, 1'b0);
    wr(IDX_CTRL_B, 8'h38);
    rc(IDX_CTRL_B, 8'h08);
    wr(IDX_CTRL_B, 8'h00);
  endtask

  // Wrap from F0 passes both match values and the overflow
  task automatic t_flags;
    wr(IDX_CTRL_A, 8'h50);
    wr(IDX_MATCH_A, 8'h05);
    wr(IDX_MATCH_B, 8'h08);
    wr(IDX_COUNT, 8'hF0);
    wr(IDX_MASK, 8'h07);
    wr(IDX_GIE, 8'h01);
    pc("irq idle", irq, 1'b0);
    wr(IDX_CTRL_B, 8'h01);
    tick(30);
    wr(IDX_CTRL_B, 8'h00);
    rc(IDX_FLAGS, 8'h07);
    pc("match toggle a", wave_a, 1'b1);
    pc("match toggle b", wave_b, 1'b1);
    pc("irq set", irq, 1'b1);
    wr(IDX_FLAGS, 8'h02);
    rc(IDX_FLAGS, 8'h05);
    vack <= 3'b001;
    tick(1);
    vack <= 3'b000;
    rc(IDX_FLAGS, 8'h04);
    wr(IDX_MASK, 8'h03);
    pc("irq masked", irq, 1'b0);
    wr(IDX_MASK, 8'h04);
    pc("irq b", irq, 1'b1);
    wr(IDX_GIE, 8'h00);
    pc("irq global off", irq, 1'b0);
    wr(IDX_FCLR, 8'h04);
    rc(IDX_FLAGS, 8'h00);
  endtask

  // Counter written equal to match A: the first tick must not flag it
  task automatic t_block;
    wr(IDX_MATCH_A, 8'h20);
    wr(IDX_COUNT, 8'h20);
    tick(40);
    rc(IDX_COUNT, 8'h20);
    wr(IDX_CTRL_B, 8'h01);
    tick(4);
    wr(IDX_CTRL_B, 8'h00);
    rc(IDX_FLAGS, 8'h00);
    pc("blocked no toggle", wave_a, 1'b1);
    // Phase-correct mode: no overflow at the top, only on the turn at zero
    wr(IDX_CTRL_A, 8'h01);
    wr(IDX_COUNT, 8'hFE);
    // force bits written as zero while a PWM mode runs
    wr(IDX_CTRL_B, 8'h01);
    tick(10);
    rc(IDX_FLAGS, 8'h00);
    tick(300);
    wr(IDX_CTRL_B, 8'h00);
    rc(IDX_FLAGS, 8'h07);
    wr(IDX_FCLR, 8'h07);
    wr(IDX_CTRL_A, 8'h00);
  endtask

  // Prescaler reset first so each divider starts from a known phase
  task automatic t_clksel;
    int d;
    for (int k = 1; k < 8; k++) begin
      d = (k == 1) ? 1 : (k == 2) ? 8 : (k == 7) ? 1024 : 1 << (k + 2);
      wr(IDX_COUNT, 8'h00);
      wr(IDX_GTC, 8'h02);
      wr(IDX_CTRL_B, 8'(k));
      tick(8 * d);
      wr(IDX_CTRL_B, 8'h00);
      rd(IDX_COUNT);
      chk($sformatf("ticks %0d", k), 32'(rdat >= 8 && rdat <= 9 + 16 / d), 32'h1);
    end
  endtask

  task automatic t_async;
    wr(IDX_GTC, 8'h02);
    rc(IDX_GTC, 8'h00);
    wr(IDX_ASYNC, 8'h40);
    pc("pin buffer sync", ext_buf, 1'b0);
    wr(IDX_ASYNC, 8'h60);
    pc("pin buffer", ext_buf, 1'b1);
    pc("crystal off", osc_run, 1'b0);
    // each register written only while its own busy bit is clear
    wr(IDX_MATCH_A, 8'h3C);
    rc(IDX_ASYNC, 8'h68);
    wr(IDX_COUNT, 8'h11);
    rc(IDX_ASYNC, 8'h78);
    rc(IDX_MATCH_A, 8'h3C);
    edges;
    rc(IDX_ASYNC, 8'h60);
    rc(IDX_COUNT, 8'h11);
    wr(IDX_GTC, 8'h02);
    rc(IDX_GTC, 8'h02);
    edges;
    rc(IDX_GTC, 8'h00);
    wr(IDX_GTC, 8'h82);
    edges;
    rc(IDX_GTC, 8'h82);
    wr(IDX_GTC, 8'h00);
    wr(IDX_ASYNC, 8'h20);
    pc("crystal on", osc_run, 1'b1);
  endtask

  task automatic t_unmapped;
    wr(10'h3FF, 8'h5A);
    chk("write resp", 32'(brsp), 32'(RESP_SLVERR));
    rd(10'h3FF);
    chk("read resp", 32'(rrsp), 32'(RESP_SLVERR));
    chk("read data", rdat, 32'h0);
  endtask

  // --------------
  // Run control
  // --------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Whole run needs about 13000 cycles; three times that means a hang
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    complete_run;
  end

  initial begin
    {rst_b, osc, bready, rready, awvalid, wvalid, arvalid} = '0;
    {awaddr, araddr, wdata, vack} = '0;
    tick(6);
    rst_b <= 1'b1;
    tick(2);
    t_force;
    t_flags;
    t_block;
    t_clksel;
    t_unmapped;
    t_async;
    complete_run;
  end
endmodule
`default_nettype wire
